// file: tfic_map.vh
// register map, field positions, reset values and timing constants
// of the timer flag and input capture block.
// assumes: included by tfic_top.v only; apb word index = paddr[7:2].
`ifndef TFIC_MAP_VH
`define TFIC_MAP_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define TFIC_IDX_CTRL      6'h12
`define TFIC_IDX_FLAGS     6'h13
`define TFIC_IDX_CAP1_HI   6'h14
`define TFIC_IDX_CAP1_LO   6'h15
`define TFIC_IDX_CMP1_HI   6'h16
`define TFIC_IDX_CMP1_LO   6'h17
`define TFIC_IDX_CNT_HI    6'h18
`define TFIC_IDX_CNT_LO    6'h19
`define TFIC_IDX_ALT_HI    6'h1A
`define TFIC_IDX_ALT_LO    6'h1B
`define TFIC_IDX_CAP2_HI   6'h1C
`define TFIC_IDX_CAP2_LO   6'h1D
`define TFIC_IDX_CMP2_HI   6'h1E
`define TFIC_IDX_CMP2_LO   6'h1F
`define TFIC_ADDR_HI_ZERO  4'h0
`define TFIC_ALIGN_ZERO    2'h0

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TFIC_CTRL_CAP_IE   7
`define TFIC_CTRL_CMP_IE   6
`define TFIC_CTRL_OVF_IE   5
`define TFIC_CTRL_EDGE1    1
`define TFIC_CTRL_MASK     8'hE2
`define TFIC_CTRL_RST      8'h00

// ----------------------------------------
// flag vector positions (register bits 7..3)
// ----------------------------------------
`define TFIC_FL_CAP1       4
`define TFIC_FL_CMP1       3
`define TFIC_FL_OVF        2
`define TFIC_FL_CAP2       1
`define TFIC_FL_CMP2       0
`define TFIC_FL_NUM        5
`define TFIC_FL_RST        5'h00
`define TFIC_FL_PAD        3'h0

// ----------------------------------------
// counter and reset values
// ----------------------------------------
`define TFIC_CNT_RST       16'hFFFC
`define TFIC_CNT_MAX       16'hFFFF
`define TFIC_CNT_ONE       16'h0001
`define TFIC_PRESC_RST     2'h0
`define TFIC_PRESC_ONE     2'h1
`define TFIC_PRESC_LAST    2'h3
`define TFIC_CMP_RST       16'h0000
`define TFIC_BYTE_ZERO     8'h00
`define TFIC_WORD_ZERO     32'h0000_0000
`define TFIC_SYNC_RST      3'h0
`define TFIC_FILL_RST      3'h0

`endif

// file: tfic_top.v
// timer status flags, dual input capture, free-running counter and
// two compare registers behind an apb slave.
// assumes: capture pins are asynchronous; apb master on pclk.
module tfic_top (
	// apb clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// capture pins
	input  wire        capture_in1,
	input  wire        capture_in2,
	// interrupt request
	output reg         timer_irq
);

`include "tfic_map.vh"

// ----------------------------------------
// declarations
// ----------------------------------------
reg  [7:0]  timer_control_reg;
wire [4:0]  flags;
reg  [1:0]  presc;
reg  [15:0] counter;
reg  [15:0] cnt_d1;
reg  [15:0] cnt_d2;
reg  [15:0] capture_reg_one;
reg  [15:0] capture_reg_two;
reg  [15:0] compare_reg_one;
reg  [15:0] compare_reg_two;
reg         lock1;
reg         lock2;
reg  [2:0]  sync1;
reg  [2:0]  sync2;
reg  [2:0]  sync_fill;
reg  [31:0] next_prdata;
reg         next_err;
wire [5:0]  idx;
wire        addr_ok;
wire        acc;
wire        rd;
wire        wr;
wire        tick;
wire [15:0] cnt_inc;
wire        edge1;
wire        edge2;
wire        load1;
wire        load2;
wire        hold1;
wire        hold2;
wire        status_acc;
wire [4:0]  set_ev;
wire [4:0]  clr_ev;
wire [15:0] cap_val;
wire [7:0]  flags_byte;

// ----------------------------------------
// apb decode
// ----------------------------------------
assign idx     = paddr[7:2];
assign addr_ok = (paddr[11:8] == `TFIC_ADDR_HI_ZERO) &&
	(paddr[1:0] == `TFIC_ALIGN_ZERO) &&
	(idx >= `TFIC_IDX_CTRL) && (idx <= `TFIC_IDX_CMP2_LO);
// the transfer completes at the edge where pready is seen high
assign acc     = psel & penable & pready;
assign rd      = acc & ~pwrite & addr_ok;
assign wr      = acc & pwrite & addr_ok;

assign flags_byte = {flags, `TFIC_FL_PAD};

always @* begin
	next_prdata = `TFIC_WORD_ZERO;
	next_err    = ~addr_ok;
	case (idx)
		`TFIC_IDX_CTRL:    next_prdata[7:0] = timer_control_reg;
		`TFIC_IDX_FLAGS:   next_prdata[7:0] = flags_byte;
		`TFIC_IDX_CAP1_HI: next_prdata[7:0] = capture_reg_one[15:8];
		`TFIC_IDX_CAP1_LO: next_prdata[7:0] = capture_reg_one[7:0];
		`TFIC_IDX_CMP1_HI: next_prdata[7:0] = compare_reg_one[15:8];
		`TFIC_IDX_CMP1_LO: next_prdata[7:0] = compare_reg_one[7:0];
		`TFIC_IDX_CNT_HI:  next_prdata[7:0] = counter[15:8];
		`TFIC_IDX_CNT_LO:  next_prdata[7:0] = counter[7:0];
		`TFIC_IDX_ALT_HI:  next_prdata[7:0] = counter[15:8];
		`TFIC_IDX_ALT_LO:  next_prdata[7:0] = counter[7:0];
		`TFIC_IDX_CAP2_HI: next_prdata[7:0] = capture_reg_two[15:8];
		`TFIC_IDX_CAP2_LO: next_prdata[7:0] = capture_reg_two[7:0];
		`TFIC_IDX_CMP2_HI: next_prdata[7:0] = compare_reg_two[15:8];
		`TFIC_IDX_CMP2_LO: next_prdata[7:0] = compare_reg_two[7:0];
		default:           next_prdata[7:0] = `TFIC_BYTE_ZERO;
	endcase
	if (~addr_ok) begin
		next_prdata = `TFIC_WORD_ZERO;
	end
end

// one wait state: pready rises in the second access cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= `TFIC_WORD_ZERO;
	end else begin
		pready  <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & next_err;
		if (psel & penable & ~pready & (~pwrite | next_err)) begin
			prdata <= next_prdata;
		end
	end
end

// ----------------------------------------
// control and compare registers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		timer_control_reg <= `TFIC_CTRL_RST;
		compare_reg_one   <= `TFIC_CMP_RST;
		compare_reg_two   <= `TFIC_CMP_RST;
	end else if (wr) begin
		case (idx)
			`TFIC_IDX_CTRL:    timer_control_reg <= pwdata[7:0] & `TFIC_CTRL_MASK;
			`TFIC_IDX_CMP1_HI: compare_reg_one[15:8] <= pwdata[7:0];
			`TFIC_IDX_CMP1_LO: compare_reg_one[7:0]  <= pwdata[7:0];
			`TFIC_IDX_CMP2_HI: compare_reg_two[15:8] <= pwdata[7:0];
			`TFIC_IDX_CMP2_LO: compare_reg_two[7:0]  <= pwdata[7:0];
			default: begin
				timer_control_reg <= timer_control_reg;
			end
		endcase
	end
end

// ----------------------------------------
// prescaler and free-running counter
// ----------------------------------------
assign tick    = (presc == `TFIC_PRESC_LAST);
assign cnt_inc = counter + `TFIC_CNT_ONE;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		presc   <= `TFIC_PRESC_RST;
		counter <= `TFIC_CNT_RST;
		cnt_d1  <= `TFIC_CNT_RST;
		cnt_d2  <= `TFIC_CNT_RST;
	end else begin
		presc  <= presc + `TFIC_PRESC_ONE;
		cnt_d1 <= counter;
		cnt_d2 <= cnt_d1;
		if (tick) begin
			counter <= cnt_inc;
		end
	end
end

// ----------------------------------------
// capture pin synchronisers and edge detect
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sync1     <= `TFIC_SYNC_RST;
		sync2     <= `TFIC_SYNC_RST;
		sync_fill <= `TFIC_FILL_RST;
	end else begin
		sync1     <= {sync1[1:0], capture_in1};
		sync2     <= {sync2[1:0], capture_in2};
		sync_fill <= {sync_fill[1:0], 1'b1};
	end
end

// stage 0 is read only by stage 1; compare stages 1 and 2
// edges count only once both stages hold real pin levels
assign edge1 = sync_fill[2] & (timer_control_reg[`TFIC_CTRL_EDGE1] ?
	(sync1[1] & ~sync1[2]) : (~sync1[1] & sync1[2]));
assign edge2 = sync_fill[2] & ~sync2[1] & sync2[2];

// a high byte read in flight blocks too, so both bytes match
assign hold1 = psel & penable & ~pwrite & addr_ok & (idx == `TFIC_IDX_CAP1_HI);
assign hold2 = psel & penable & ~pwrite & addr_ok & (idx == `TFIC_IDX_CAP2_HI);

// a low byte read in the same cycle releases the lock at once
assign load1 = edge1 & ~hold1 &
	(~lock1 | (rd & (idx == `TFIC_IDX_CAP1_LO)));
assign load2 = edge2 & ~hold2 &
	(~lock2 | (rd & (idx == `TFIC_IDX_CAP2_LO)));

// counter as it was while the pin changed, plus one
assign cap_val = cnt_d2 + `TFIC_CNT_ONE;

// ----------------------------------------
// capture registers: not touched by reset
// ----------------------------------------
always @(posedge pclk) begin
	if (load1) begin
		capture_reg_one <= cap_val;
	end
	if (load2) begin
		capture_reg_two <= cap_val;
	end
end

// ----------------------------------------
// capture read locks
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		lock1 <= 1'b0;
		lock2 <= 1'b0;
	end else begin
		if (rd && idx == `TFIC_IDX_CAP1_HI) begin
			lock1 <= 1'b1;
		end else if (rd && idx == `TFIC_IDX_CAP1_LO) begin
			lock1 <= 1'b0;
		end
		if (rd && idx == `TFIC_IDX_CAP2_HI) begin
			lock2 <= 1'b1;
		end else if (rd && idx == `TFIC_IDX_CAP2_LO) begin
			lock2 <= 1'b0;
		end
	end
end

// ----------------------------------------
// flag set and clear events
// ----------------------------------------
assign set_ev[`TFIC_FL_CAP1] = edge1;
assign set_ev[`TFIC_FL_CMP1] = tick & (cnt_inc == compare_reg_one);
assign set_ev[`TFIC_FL_OVF]  = tick & (counter == `TFIC_CNT_MAX);
assign set_ev[`TFIC_FL_CAP2] = edge2;
assign set_ev[`TFIC_FL_CMP2] = tick & (cnt_inc == compare_reg_two);

// status read or write arms each flag that is already set
assign status_acc = acc & addr_ok & (idx == `TFIC_IDX_FLAGS);

assign clr_ev[`TFIC_FL_CAP1] = rd & (idx == `TFIC_IDX_CAP1_LO);
assign clr_ev[`TFIC_FL_CMP1] = (rd | wr) & (idx == `TFIC_IDX_CMP1_LO);
// alternate counter low read never clears overflow
assign clr_ev[`TFIC_FL_OVF]  = rd & (idx == `TFIC_IDX_CNT_LO);
assign clr_ev[`TFIC_FL_CAP2] = rd & (idx == `TFIC_IDX_CAP2_LO);
assign clr_ev[`TFIC_FL_CMP2] = (rd | wr) & (idx == `TFIC_IDX_CMP2_LO);

// ----------------------------------------
// flag registers
// ----------------------------------------
tfic_flag u_flag_cap1 (
	.pclk       (pclk),
	.presetn    (presetn),
	.set_ev     (set_ev[`TFIC_FL_CAP1]),
	.clr_ev     (clr_ev[`TFIC_FL_CAP1]),
	.status_acc (status_acc),
	.flag       (flags[`TFIC_FL_CAP1])
);

tfic_flag u_flag_cmp1 (
	.pclk       (pclk),
	.presetn    (presetn),
	.set_ev     (set_ev[`TFIC_FL_CMP1]),
	.clr_ev     (clr_ev[`TFIC_FL_CMP1]),
	.status_acc (status_acc),
	.flag       (flags[`TFIC_FL_CMP1])
);

tfic_flag u_flag_ovf (
	.pclk       (pclk),
	.presetn    (presetn),
	.set_ev     (set_ev[`TFIC_FL_OVF]),
	.clr_ev     (clr_ev[`TFIC_FL_OVF]),
	.status_acc (status_acc),
	.flag       (flags[`TFIC_FL_OVF])
);

tfic_flag u_flag_cap2 (
	.pclk       (pclk),
	.presetn    (presetn),
	.set_ev     (set_ev[`TFIC_FL_CAP2]),
	.clr_ev     (clr_ev[`TFIC_FL_CAP2]),
	.status_acc (status_acc),
	.flag       (flags[`TFIC_FL_CAP2])
);

tfic_flag u_flag_cmp2 (
	.pclk       (pclk),
	.presetn    (presetn),
	.set_ev     (set_ev[`TFIC_FL_CMP2]),
	.clr_ev     (clr_ev[`TFIC_FL_CMP2]),
	.status_acc (status_acc),
	.flag       (flags[`TFIC_FL_CMP2])
);

// ----------------------------------------
// interrupt request
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		timer_irq <= 1'b0;
	end else begin
		timer_irq <=
			((flags[`TFIC_FL_CAP1] | flags[`TFIC_FL_CAP2]) &
				timer_control_reg[`TFIC_CTRL_CAP_IE]) |
			((flags[`TFIC_FL_CMP1] | flags[`TFIC_FL_CMP2]) &
				timer_control_reg[`TFIC_CTRL_CMP_IE]) |
			(flags[`TFIC_FL_OVF] & timer_control_reg[`TFIC_CTRL_OVF_IE]);
	end
end

endmodule // tfic_top

// ----------------------------------------
// one status flag with its two-step clear
// ----------------------------------------
module tfic_flag (
	// clock and reset
	input  wire pclk,
	input  wire presetn,
	// events
	input  wire set_ev,
	input  wire clr_ev,
	input  wire status_acc,
	// flag
	output reg  flag
);

reg arm;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		flag <= 1'b0;
		arm  <= 1'b0;
	end else begin
		// a new event wins over a clear in the same cycle
		if (set_ev) begin
			flag <= 1'b1;
		end else if (arm & clr_ev) begin
			flag <= 1'b0;
		end
		// status access while set arms the clear
		if (status_acc & flag) begin
			arm <= 1'b1;
		end else if (clr_ev | ~flag) begin
			arm <= 1'b0;
		end
	end
end

endmodule // tfic_flag

// file: tfic_monitor.sv
// checker on the ports of tfic_top
// assumes: bound to tfic_top, one pclk domain
module tfic_monitor (
	// clock and reset
	input logic        pclk,
	input logic        presetn,
	// apb
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// pins and irq
	input logic        capture_in1,
	input logic        capture_in2,
	input logic        timer_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire bad = (paddr[11:8] != 4'h0) || (paddr[1:0] != 2'h0)
		|| (paddr[7:2] < 6'h12) || (paddr[7:2] > 6'h1F);
	// ----------------------------------------
	// bus answer and read data
	// ----------------------------------------
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
	property p_rdy_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("wait state wrong");
	property p_rdy_sel; pready |-> psel && penable; endproperty
	a_rdy_sel: assert property (p_rdy_sel) else $error("pready outside access");
	property p_map; pready |-> pslverr == bad; endproperty
	a_map: assert property (p_map) else $error("pslverr wrong");
	property p_err_zero; pslverr |-> prdata == 32'h0000_0000; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error data not zero");
	property p_hi_zero; pready |-> prdata[31:8] == 24'h00_0000; endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
	property p_flags_pad; pready && !pwrite && paddr == 12'h04C |-> prdata[2:0] == 3'h0;
	endproperty
	a_flags_pad: assert property (p_flags_pad) else $error("flag pad set");
	property p_irq_drop; $fell(timer_irq) |-> $past(pready) || $past(pready, 2); endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq fell alone");
	c_err: cover property (pslverr);
	c_irq_up: cover property ($rose(timer_irq));
	c_irq_dn: cover property ($fell(timer_irq));
endmodule // tfic_monitor

// file: tfic_pins.sv
// model of the two capture pins
// assumes: levels change after a pclk edge, held 8 clocks
module tfic_pins (
	// clock
	input  logic pclk,
	// pins
	output logic capture_in1,
	output logic capture_in2
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		capture_in1 = 1'b1;
		capture_in2 = 1'b1;
	end
	// set masked pins, then hold them stable
	task automatic pin(input logic [1:0] m, input logic [1:0] v);
		@(posedge pclk);
		if (m[0])
			capture_in1 <= v[0];
		if (m[1])
			capture_in2 <= v[1];
		repeat (7) @(posedge pclk);
	endtask
endmodule // tfic_pins

// file: tb_timer_flags_input_capture.sv
// testbench of tfic_top over apb
// assumes: tfic_pins drives the capture pins
module tb_timer_flags_input_capture;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        capture_in1;
	logic        capture_in2;
	logic        timer_irq;
	logic [31:0] r;
	logic        ser;
	logic [15:0] v;
	logic [15:0] w;
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	tfic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_in1(capture_in1),
		.capture_in2(capture_in2), .timer_irq(timer_irq));
	tfic_pins pins (.pclk(pclk), .capture_in1(capture_in1), .capture_in2(capture_in2));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] i, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {4'h0, i, 2'h0};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (t == 50)
			err_count++;
		r = prdata;
		ser = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic reset_dut();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		reset_dut();
		repeat (30) @(posedge pclk);
		bus(0, 6'h12, 8'h00);
		chk("ctrl", r, 8'h00);
		bus(0, 6'h13, 8'h00);
		chk("flags", r, 8'h68);
		bus(0, 6'h1B, 8'h00);
		bus(0, 6'h13, 8'h00);
		chk("flags alt", r, 8'h68);
		bus(0, 6'h19, 8'h00);
		bus(0, 6'h17, 8'h00);
		bus(1, 6'h1F, 8'h00);
		bus(0, 6'h13, 8'h00);
		chk("flags clr", r, 8'h00);
		bus(0, 6'h11, 8'h00);
		chk("unmapped", ser, 1'b1);
		$display("test flags done");
		bus(1, 6'h12, 8'h80);
		pins.pin(2'b01, 2'b00);
		chk("irq cap1", timer_irq, 1'b1);
		bus(0, 6'h13, 8'h00);
		chk("flags cap1", r, 8'h80);
		bus(0, 6'h15, 8'h00);
		bus(0, 6'h13, 8'h00);
		chk("flags clr1", r, 8'h00);
		chk("irq clr1", timer_irq, 1'b0);
		$display("test capture one done");
		bus(1, 6'h12, 8'h82);
		pins.pin(2'b10, 2'b00);
		pins.pin(2'b01, 2'b01);
		pins.pin(2'b11, 2'b10);
		bus(0, 6'h1C, 8'h00);
		w[15:8] = r[7:0];
		bus(0, 6'h1D, 8'h00);
		w[7:0] = r[7:0];
		bus(0, 6'h14, 8'h00);
		v[15:8] = r[7:0];
		bus(0, 6'h15, 8'h00);
		v[7:0] = r[7:0];
		chk("cap spacing", v, w + 16'h0002);
		bus(0, 6'h14, 8'h00);
		bus(0, 6'h1C, 8'h00);
		pins.pin(2'b11, 2'b01);
		bus(0, 6'h15, 8'h00);
		chk("cap1 locked", r, v[7:0]);
		bus(0, 6'h1D, 8'h00);
		chk("cap2 locked", r, w[7:0]);
		bus(0, 6'h13, 8'h00);
		chk("flags cap", r, 8'h90);
		chk("irq cap", timer_irq, 1'b1);
		bus(1, 6'h12, 8'h02);
		bus(0, 6'h12, 8'h00);
		chk("irq masked", timer_irq, 1'b0);
		bus(1, 6'h13, 8'h00);
		bus(0, 6'h1D, 8'h00);
		bus(0, 6'h15, 8'h00);
		bus(0, 6'h13, 8'h00);
		chk("flags clr2", r, 8'h00);
		$display("test capture two done");
		reset_dut();
		bus(0, 6'h14, 8'h00);
		chk("cap1 hi rst", r, v[15:8]);
		bus(0, 6'h15, 8'h00);
		chk("cap1 lo rst", r, v[7:0]);
		repeat (40) @(posedge pclk);
		bus(1, 6'h12, 8'h20);
		bus(1, 6'h13, 8'h00);
		chk("irq ovf", timer_irq, 1'b1);
		bus(0, 6'h19, 8'h00);
		bus(1, 6'h12, 8'h40);
		chk("irq ovf clr", timer_irq, 1'b0);
		bus(0, 6'h13, 8'h00);
		chk("flags cmp", r, 8'h48);
		chk("irq cmp", timer_irq, 1'b1);
		$display("test reset done");
		tally_and_finish();
	end
endmodule // tb_timer_flags_input_capture
bind tfic_top tfic_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_in1(capture_in1),
	.capture_in2(capture_in2), .timer_irq(timer_irq));
